// ---- src/pae_alarm_evaluator.sv ----
// Process alarm evaluator: per-channel deviation, band and absolute
// alarms with standby sequence and on/off delays, routed to aux outputs.
// Assumes process value and set point arrive on sys_clk_i from the
// measurement logic; settings are written over APB by the controller.
`timescale 1ns/100ps
`default_nettype none

module pae_alarm_evaluator
    import pae_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic signed [VAL_W-1:0] process_value_i,
    input wire logic signed [VAL_W-1:0] set_point_i,
    input wire logic standby_restart_i,
    input wire logic heater_variant_i,
    input wire logic heater_fault_alarm_i,
    output logic [NUM_CH-1:0] alarm_o,
    output logic [NUM_AUX-1:0] aux_out_o
);

    localparam int TICK_W = $clog2(TICK_COUNT + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_COUNT - 1);

    logic [TYPE_W-1:0] type_reg [NUM_CH];
    logic [VAL_W-1:0] high_reg [NUM_CH];
    logic [VAL_W-1:0] low_reg [NUM_CH];
    logic [DLY_W-1:0] on_dly_reg [NUM_CH];
    logic [DLY_W-1:0] off_dly_reg [NUM_CH];
    logic [ALLOC_W-1:0] alloc_reg [NUM_AUX];
    logic assign_reg;
    logic variant_reg;
    logic strap_done_reg;
    logic [31:0] prdata_reg;
    logic [TICK_W-1:0] tick_cnt_reg;
    logic sec_tick;
    logic [NUM_CH-1:0] raw_alarm;
    logic [NUM_CH-1:0] out_reg;
    logic [NUM_CH-1:0] standby_reg;
    logic [NUM_CH-1:0] type_wr;
    logic hidden;
    logic setup_ph;
    logic access_ph;
    logic hit_ch;
    logic hit_status;
    logic hit_ctrl;
    logic mapped;
    logic [3:0] ch_ofs;
    logic [3:0] ch_idx;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [31:0] ctrl_word;

    // APB decode; data is latched in setup so prdata comes from a flop
    assign setup_ph = psel_i && !penable_i;
    assign access_ph = psel_i && penable_i;
    assign ch_idx = paddr_i[7:4];
    assign ch_ofs = paddr_i[3:0];
    assign hit_ch = (32'(ch_idx) < NUM_CH) && (paddr_i[1:0] == 2'h0);
    assign hit_status = (paddr_i == ADDR_STATUS);
    assign hit_ctrl = (paddr_i == ADDR_CTRL);
    assign mapped = hit_ch || hit_status || hit_ctrl;
    assign pready_o = access_ph;
    assign pslverr_o = access_ph && !mapped;
    assign prdata_o = prdata_reg;

    assign hidden = variant_reg && !assign_reg;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_OUT_LSB +: NUM_CH] = out_reg;
        status_word[ST_RAW_LSB +: NUM_CH] = raw_alarm;
        status_word[ST_STBY_LSB +: NUM_CH] = standby_reg;
        status_word[ST_HIDDEN_BIT] = hidden;
    end

    always_comb
    begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[CTRL_ASSIGN_BIT] = assign_reg;
        for (int a = 0; a < NUM_AUX; a++)
        begin
            ctrl_word[CTRL_ALLOC_LSB + a*ALLOC_W +: ALLOC_W] = alloc_reg[a];
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_status)
        begin
            rd_mux = status_word;
        end
        else if (hit_ctrl)
        begin
            rd_mux = ctrl_word;
        end
        else if (hit_ch)
        begin
            unique case (ch_ofs)
                OFS_TYPE:
                begin
                    // Channel 0 type reads zero while it carries the heater alarm
                    if (!(hidden && ch_idx == 4'h0))
                    begin
                        rd_mux[TYPE_W-1:0] = type_reg[ch_idx[0]];
                    end
                end
                OFS_HIGH: rd_mux[VAL_W-1:0] = high_reg[ch_idx[0]];
                OFS_LOW: rd_mux[VAL_W-1:0] = low_reg[ch_idx[0]];
                OFS_DELAY:
                begin
                    rd_mux[DLY_ON_LSB +: DLY_W] = on_dly_reg[ch_idx[0]];
                    rd_mux[DLY_OFF_LSB +: DLY_W] = off_dly_reg[ch_idx[0]];
                end
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prdata_reg <= 32'h0000_0000;
        end
        else if (ce_i && setup_ph && !pwrite_i)
        begin
            prdata_reg <= rd_mux;
        end
    end

    // Strap is caught on the first enabled edge after reset release
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            variant_reg <= 1'b0;
            strap_done_reg <= 1'b0;
        end
        else if (ce_i && !strap_done_reg)
        begin
            variant_reg <= heater_variant_i;
            strap_done_reg <= 1'b1;
        end
    end

    // Settings written in the access phase; delays above 999 saturate
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                type_reg[c] <= TYPE_RESET;
                high_reg[c] <= VAL_RESET;
                low_reg[c] <= VAL_RESET;
                on_dly_reg[c] <= '0;
                off_dly_reg[c] <= '0;
            end
        end
        else if (ce_i && access_ph && pwrite_i && hit_ch)
        begin
            unique case (ch_ofs)
                OFS_TYPE: type_reg[ch_idx[0]] <= pwdata_i[TYPE_W-1:0];
                OFS_HIGH: high_reg[ch_idx[0]] <= pwdata_i[VAL_W-1:0];
                OFS_LOW: low_reg[ch_idx[0]] <= pwdata_i[VAL_W-1:0];
                OFS_DELAY:
                begin
                    on_dly_reg[ch_idx[0]] <=
                        (pwdata_i[DLY_ON_LSB +: DLY_W] > DLY_MAX) ?
                        DLY_MAX : pwdata_i[DLY_ON_LSB +: DLY_W];
                    off_dly_reg[ch_idx[0]] <=
                        (pwdata_i[DLY_OFF_LSB +: DLY_W] > DLY_MAX) ?
                        DLY_MAX : pwdata_i[DLY_OFF_LSB +: DLY_W];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            assign_reg <= 1'b0;
            for (int a = 0; a < NUM_AUX; a++)
            begin
                alloc_reg[a] <= ALLOC_W'(a + 1);
            end
        end
        else if (ce_i && access_ph && pwrite_i && hit_ctrl)
        begin
            assign_reg <= pwdata_i[CTRL_ASSIGN_BIT];
            for (int a = 0; a < NUM_AUX; a++)
            begin
                alloc_reg[a] <=
                    pwdata_i[CTRL_ALLOC_LSB + a*ALLOC_W +: ALLOC_W];
            end
        end
    end

    // Shared one-second time base for all delay counters
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tick_cnt_reg <= '0;
        end
        else if (ce_i)
        begin
            tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? '0 :
                            tick_cnt_reg + TICK_W'(1);
        end
    end
    assign sec_tick = (tick_cnt_reg == TICK_LAST);

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic signed [VAL_W+1:0] dev;
            logic signed [VAL_W+1:0] hi_s;
            logic signed [VAL_W+1:0] lo_s;
            logic signed [VAL_W+1:0] pv_s;
            logic outside;
            logic cond;
            logic with_sb;
            logic [DLY_W-1:0] cnt_reg;
            logic [DLY_W-1:0] limit;

            assign pv_s = (VAL_W+2)'(process_value_i);
            assign dev = pv_s - (VAL_W+2)'(set_point_i);
            assign hi_s = (VAL_W+2)'($signed(high_reg[g]));
            assign lo_s = (VAL_W+2)'($signed(low_reg[g]));
            assign outside = (dev >= hi_s) || (dev <= -lo_s);
            assign type_wr[g] = access_ph && pwrite_i && hit_ch &&
                                (ch_ofs == OFS_TYPE) &&
                                (ch_idx == 4'(g));

            always_comb
            begin
                cond = 1'b0;
                with_sb = 1'b0;
                unique case (type_reg[g])
                    PAE_OFF: cond = 1'b0;
                    PAE_DEV_BAND: cond = outside;
                    PAE_DEV_UPPER: cond = (dev >= hi_s);
                    PAE_DEV_LOWER: cond = (dev <= -hi_s);
                    PAE_DEV_INSIDE: cond = !outside;
                    PAE_DEV_BAND_SB:
                    begin
                        cond = outside;
                        with_sb = 1'b1;
                    end
                    PAE_DEV_UPPER_SB:
                    begin
                        cond = (dev >= hi_s);
                        with_sb = 1'b1;
                    end
                    PAE_DEV_LOWER_SB:
                    begin
                        cond = (dev <= -hi_s);
                        with_sb = 1'b1;
                    end
                    PAE_ABS_UPPER: cond = (pv_s > hi_s);
                    PAE_ABS_LOWER: cond = (pv_s < hi_s);
                    PAE_ABS_UPPER_SB:
                    begin
                        cond = (pv_s > hi_s);
                        with_sb = 1'b1;
                    end
                    PAE_ABS_LOWER_SB:
                    begin
                        cond = (pv_s < hi_s);
                        with_sb = 1'b1;
                    end
                    // Unsupported codes behave as alarm off
                    default: cond = 1'b0;
                endcase
            end

            // Standby arms at reset, on restart and on a type write
            always_ff @(posedge sys_clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    standby_reg[g] <= 1'b1;
                end
                else if (ce_i)
                begin
                    if (standby_restart_i || type_wr[g])
                    begin
                        standby_reg[g] <= 1'b1;
                    end
                    else if (!cond)
                    begin
                        standby_reg[g] <= 1'b0;
                    end
                end
            end

            assign raw_alarm[g] = cond && !(with_sb && standby_reg[g]);

            // Count whole seconds while raw and output disagree
            assign limit = raw_alarm[g] ? on_dly_reg[g] : off_dly_reg[g];

            always_ff @(posedge sys_clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    cnt_reg <= '0;
                    out_reg[g] <= 1'b0;
                end
                else if (ce_i)
                begin
                    if (raw_alarm[g] == out_reg[g])
                    begin
                        cnt_reg <= '0;
                    end
                    else if (cnt_reg >= limit)
                    begin
                        out_reg[g] <= raw_alarm[g];
                        cnt_reg <= '0;
                    end
                    else if (sec_tick)
                    begin
                        cnt_reg <= cnt_reg + DLY_W'(1);
                    end
                end
            end
        end
    endgenerate

    // On the heater variant, channel 0 carries the heater alarm until software assigns it
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            alarm_o <= '0;
        end
        else if (ce_i)
        begin
            alarm_o <= out_reg;
            if (hidden)
            begin
                alarm_o[0] <= heater_fault_alarm_i;
            end
        end
    end

    generate
        for (g = 0; g < NUM_AUX; g++)
        begin : g_aux
            always_ff @(posedge sys_clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    aux_out_o[g] <= 1'b0;
                end
                else if (ce_i)
                begin
                    unique case (alloc_reg[g])
                        ALLOC_NONE: aux_out_o[g] <= 1'b0;
                        ALLOC_CH0: aux_out_o[g] <= hidden ?
                            heater_fault_alarm_i : out_reg[0];
                        ALLOC_CH1: aux_out_o[g] <= out_reg[1];
                        ALLOC_HEATER: aux_out_o[g] <= heater_fault_alarm_i;
                    endcase
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ---- src/pae_pkg.sv ----
// Constants shared by the process alarm evaluator: register map, field
// layout, reset values, alarm-type codes and timing.
// Assumes a 40 MHz controller clock and a 32-bit APB register bus.
package pae_pkg;
    localparam int NUM_CH = 2;
    localparam int NUM_AUX = 2;
    localparam int VAL_W = 16;
    localparam int TYPE_W = 5;
    localparam int DLY_W = 10;
    localparam int ALLOC_W = 2;

    // Per-channel block: base = ch * CH_STRIDE
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [3:0] OFS_TYPE = 4'h0;
    localparam logic [3:0] OFS_HIGH = 4'h4;
    localparam logic [3:0] OFS_LOW = 4'h8;
    localparam logic [3:0] OFS_DELAY = 4'hC;
    localparam logic [7:0] ADDR_STATUS = 8'h40;
    localparam logic [7:0] ADDR_CTRL = 8'h44;

    // Delay register fields
    localparam int DLY_ON_LSB = 0;
    localparam int DLY_OFF_LSB = 16;
    localparam logic [DLY_W-1:0] DLY_MAX = 10'h3E7;

    // Control register fields
    localparam int CTRL_ASSIGN_BIT = 0;
    localparam int CTRL_ALLOC_LSB = 4;

    // Status register fields, one bit per channel each except the single hidden bit
    localparam int ST_OUT_LSB = 0;
    localparam int ST_RAW_LSB = 8;
    localparam int ST_STBY_LSB = 16;
    localparam int ST_HIDDEN_BIT = 24;

    typedef enum logic [TYPE_W-1:0] {
        PAE_OFF = 5'h00,
        PAE_DEV_BAND = 5'h01,
        PAE_DEV_UPPER = 5'h02,
        PAE_DEV_LOWER = 5'h03,
        PAE_DEV_INSIDE = 5'h04,
        PAE_DEV_BAND_SB = 5'h05,
        PAE_DEV_UPPER_SB = 5'h06,
        PAE_DEV_LOWER_SB = 5'h07,
        PAE_ABS_UPPER = 5'h08,
        PAE_ABS_LOWER = 5'h09,
        PAE_ABS_UPPER_SB = 5'h0A,
        PAE_ABS_LOWER_SB = 5'h0B
    } pae_type_t;

    localparam logic [TYPE_W-1:0] TYPE_RESET = 5'h02;
    localparam logic [VAL_W-1:0] VAL_RESET = 16'h0000;

    // Output allocation codes
    localparam logic [ALLOC_W-1:0] ALLOC_NONE = 2'h0;
    localparam logic [ALLOC_W-1:0] ALLOC_CH0 = 2'h1;
    localparam logic [ALLOC_W-1:0] ALLOC_CH1 = 2'h2;
    localparam logic [ALLOC_W-1:0] ALLOC_HEATER = 2'h3;

    // Delay time base: one second
    localparam longint CLK_HZ = 40000000;
    localparam longint TICK_S = 1;
    localparam int TICK_CYCLES = int'(CLK_HZ * TICK_S);
endpackage

// ---- verif/pae_alarm_evaluator_chk.sv ----
// Port-level checker for the process alarm evaluator.
// Assumes one clock domain and a zero-wait APB slave.
`timescale 1ns/100ps
`default_nettype none

module pae_alarm_evaluator_chk
    import pae_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [NUM_CH-1:0] alarm_o,
    input wire logic [NUM_AUX-1:0] aux_out_o
);
    logic access;
    logic mapped;
    logic rd_setup;
    assign access = psel_i && penable_i;
    assign rd_setup = psel_i && !penable_i && !pwrite_i && ce_i;
    assign mapped = paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
        8'h14, 8'h18, 8'h1C, ADDR_STATUS, ADDR_CTRL};

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_setup;
        rd_setup;
    endsequence
    sequence s_bad_access;
        access && !pwrite_i && !mapped;
    endsequence

    chk_ready_high: assert property (access |-> pready_o)
        else $error("pready low in access");
    chk_ready_low: assert property (!access |-> !pready_o)
        else $error("pready high outside access");
    chk_err_unmapped: assert property (access && !mapped |-> pslverr_o)
        else $error("unmapped access without error");
    chk_err_quiet: assert property (pslverr_o |-> access && !mapped)
        else $error("spurious error response");
    // Read data is latched at setup, so it must not drift afterwards
    chk_rdata_hold: assert property (!rd_setup |=> $stable(prdata_o))
        else $error("read data changed without read setup");
    chk_unmapped_zero: assert property (s_setup ##1 s_bad_access
        |-> prdata_o == 32'h0)
        else $error("unmapped read returned data");
    chk_ce_freeze: assert property (!ce_i |=> $stable(alarm_o)
        && $stable(aux_out_o) && $stable(prdata_o))
        else $error("state moved while clock enable low");
    chk_reset_clear: assert property ($fell(rst_i)
        |-> alarm_o == '0 && aux_out_o == '0 && prdata_o == 32'h0)
        else $error("outputs not cleared by reset");
endmodule

`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the process alarm evaluator.
// Drives APB and process inputs directly; delay tick shortened to 10.
`timescale 1ns/100ps
`default_nettype none

module tb;
    import pae_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic restart = 1'b0, strap = 1'b0, heat = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic signed [VAL_W-1:0] pv = 16'h0000, sp = 16'h0000;
    logic pready, pslverr, err_bit;
    logic [NUM_CH-1:0] alarm, e;
    logic [NUM_AUX-1:0] aux;
    integer errors = 0, samples_checked = 0, seed = 32'h7EC3A9DA;
    integer t, c, i, p = 0, s = 0, h, a;
    integer ty [2], hi [2], lo [2], arm [2];

    always #12.5 sys_clk_i = ~sys_clk_i;

    pae_alarm_evaluator #(.TICK_COUNT(10)) DUT (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .process_value_i(pv), .set_point_i(sp),
        .standby_restart_i(restart), .heater_variant_i(strap),
        .heater_fault_alarm_i(heat), .alarm_o(alarm), .aux_out_o(aux));

    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task finish_test;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Request held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        integer n;
        @(posedge sys_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            errors++;
            finish_test;
        end
        rd = prdata;
        err_bit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        check(rd, exp);
    endtask

    task stepchk(input integer n, input logic [1:0] exp);
        repeat (n) @(posedge sys_clk_i);
        check(32'(alarm), 32'(exp));
    endtask

    function automatic integer raw(input integer k, pq, sq, hq, lq);
        integer d;
        d = pq - sq;
        case (k)
            1, 5: raw = d >= hq || d <= -lq;
            2, 6: raw = d >= hq;
            3, 7: raw = d <= -hq;
            4: raw = !(d >= hq || d <= -lq);
            8, 10: raw = pq > hq;
            9, 11: raw = pq < hq;
            default: raw = 0;
        endcase
    endfunction

    function automatic logic src(input integer k);
        src = k == 2 ? 1'b1 : k == 3 ? heat : 1'b0;
    endfunction

    initial
    begin
        repeat (50000) @(posedge sys_clk_i);
        errors++;
        finish_test;
    end

    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdchk(8'h00, 32'h2);
        rdchk(8'h10, 32'h2);
        rdchk(8'h04, 32'h0);
        rdchk(8'h1C, 32'h0);
        rdchk(ADDR_CTRL, 32'h90);
        rdchk(8'h20, 32'h0);
        check(32'(err_bit), 32'h1);
        for (t = 0; t < 13; t++)
        begin
            for (c = 0; c < 2; c++)
            begin
                ty[c] = (t + 5 * c) % 13;
                hi[c] = $random(seed) % 16;
                lo[c] = $random(seed) % 16;
                apb(1'b1, 8'(16 * c + 4), 32'(hi[c]));
                apb(1'b1, 8'(16 * c + 8), 32'(lo[c]));
                apb(1'b1, 8'(16 * c), 32'(ty[c]));
                rdchk(8'(16 * c), 32'(ty[c]));
            end
            // Standby was re-armed by the type write, then saw old inputs
            for (c = 0; c < 2; c++)
                arm[c] = raw(ty[c], p, s, hi[c], lo[c]);
            for (i = 0; i < 8; i++)
            begin
                p = $random(seed) % 24;
                s = $random(seed) % 8;
                @(posedge sys_clk_i);
                pv <= 16'(p);
                sp <= 16'(s);
                restart <= (i == 5);
                @(posedge sys_clk_i);
                restart <= 1'b0;
                for (c = 0; c < 2; c++)
                begin
                    h = raw(ty[c], p, s, hi[c], lo[c]);
                    arm[c] = (arm[c] != 0 || i == 5) && h != 0;
                    e[c] = h != 0 && !(arm[c] && ty[c] inside {5, 6, 7, 10, 11});
                end
                stepchk(4, e);
                check(32'(aux), 32'(e));
            end
        end
        @(posedge sys_clk_i);
        pv <= 16'hFFFB;
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h0C, 32'h0002_0003);
        apb(1'b1, 8'h00, 32'h8);
        apb(1'b1, 8'h10, 32'h0);
        stepchk(4, 2'b00);
        pv <= 16'h0005;
        stepchk(15, 2'b00);
        stepchk(25, 2'b01);
        pv <= 16'hFFFB;
        stepchk(8, 2'b01);
        stepchk(22, 2'b00);
        apb(1'b1, 8'h1C, 32'h03FF_03E8);
        rdchk(8'h1C, 32'h03E7_03E7);
        apb(1'b1, 8'h1C, 32'h0);
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h10, 32'h9);
        for (a = 0; a < 8; a++)
        begin
            apb(1'b1, ADDR_CTRL, 32'(((a % 4) << 4) | ((3 - a % 4) << 6)));
            heat <= 1'(a / 4);
            repeat (4) @(posedge sys_clk_i);
            check(32'(aux), 32'({src(3 - a % 4), src(a % 4)}));
        end
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        apb(1'b1, 8'h10, 32'h3);
        ce_i <= 1'b1;
        rdchk(8'h10, 32'h9);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        strap <= 1'b1;
        heat <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        check(32'(alarm[0]), 32'h1);
        rdchk(8'h00, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(32'(rd[ST_HIDDEN_BIT]), 32'h1);
        heat <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        check(32'(alarm[0]), 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h91);
        rdchk(8'h00, 32'h2);
        rdchk(8'h10, 32'h2);
        finish_test;
    end
endmodule

bind pae_alarm_evaluator pae_alarm_evaluator_chk u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .alarm_o(alarm_o), .aux_out_o(aux_out_o));

`default_nettype wire
